// ===== common/cpu_regs_pkg.sv
/*
 * Package for the CPU programmer-visible register file: register operations,
 * address modes, vector-fetch states, reset values and fixed addresses.
 * Assumes a single 20 MHz clock domain shared with the instruction sequencer.
 */
`default_nettype none
package cpu_regs_pkg;

   // Register operations requested by the sequencer, one per accepted cycle.
   typedef enum logic [3:0] {
      OP_NOP       = 4'h0,
      OP_LOAD_ACC  = 4'h1,
      OP_LOAD_X    = 4'h2,
      OP_LOAD_H    = 4'h3,
      OP_LOAD_HX   = 4'h4,
      OP_LOAD_SP   = 4'h5,
      OP_ADD_SP    = 4'h6,
      OP_RESET_SPL = 4'h7,
      OP_PUSH      = 4'h8,
      OP_PULL      = 4'h9,
      OP_PC_INC    = 4'ha,
      OP_PC_LOAD   = 4'hb,
      OP_PC_BRANCH = 4'hc,
      OP_LOAD_CCR  = 4'hd
   } reg_op_t;

   // Operand address modes handled by the address former.
   typedef enum logic [1:0] {
      AM_DIRECT   = 2'h0,
      AM_EXTENDED = 2'h1,
      AM_INDEXED  = 2'h2,
      AM_SP_INDEX = 2'h3
   } addr_mode_t;

   // Reset-vector fetch sequence.
   typedef enum logic [1:0] {
      VS_HIGH = 2'h0,
      VS_LOW  = 2'h1,
      VS_RUN  = 2'h2
   } vec_state_t;

   localparam logic [15:0] SP_RESET      = 16'h00ff;
   localparam logic [7:0]  H_RESET       = 8'h00;
   localparam logic [7:0]  SP_LOW_RESET  = 8'hff;
   localparam logic [7:0]  CCR_ONES      = 8'h60;
   localparam logic [7:0]  CCR_RESET     = 8'h68;
   localparam logic [15:0] VEC_ADDR_HIGH = 16'hfffe;
   localparam logic [15:0] VEC_ADDR_LOW  = 16'hffff;
   localparam logic [7:0]  DIRECT_PAGE   = 8'h00;

endpackage
`default_nettype wire

// ===== core/cpu_addr_former.sv
/*
 * Operand address former: builds the 16-bit effective address for direct,
 * extended, indexed and stack-indexed modes, registered for timing.
 * Assumes pointer inputs come from registers on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module cpu_addr_former
   import cpu_regs_pkg::*;
(
   // Clock and reset.
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   // Request.
   input  wire logic        req_in,
   input  wire addr_mode_t  mode_in,
   input  wire logic [15:0] operand_in,
   input  wire logic [15:0] pointer_in,
   input  wire logic [15:0] stack_in,
   // Result.
   output logic      [15:0] addr_out
);

   typedef struct packed {
      logic [15:0] addr;
   } af_state_t;

   af_state_t st_q;
   af_state_t st_d;

   // Direct stays on page zero; extended reaches all 64 Kbyte.
   always_comb
   begin
      st_d = st_q;
      if (req_in)
      begin
         case (mode_in)
            AM_DIRECT:   st_d.addr = {DIRECT_PAGE, operand_in[7:0]};
            AM_EXTENDED: st_d.addr = operand_in;
            AM_INDEXED:  st_d.addr = 16'(pointer_in + operand_in);
            AM_SP_INDEX: st_d.addr = 16'(stack_in + operand_in);
            default:     st_d.addr = operand_in;
         endcase
      end
   end

   // Address register.
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         st_q.addr <= 16'h0000;
      else
         st_q <= st_d;
   end

   assign addr_out = st_q.addr;

endmodule // cpu_addr_former
`default_nettype wire

// ===== core/cpu_register_file.sv
/*
 * CPU programmer-visible registers: accumulator, split index pointer, stack
 * pointer, program counter and condition flags, plus reset-vector fetch.
 * Assumes the sequencer issues at most one operation per cycle and that the
 * memory answers vector reads with a one-cycle acknowledge on this clock.
 */
// Functional notes
// - Accumulator is 8 bits, untouched by reset.
// - Reset clears upper pointer byte, keeps lower.
// - Indexed access uses upper:lower pointer as 16 bits.
// - Lower-byte operations leave upper pointer byte alone.
// - Reset loads stack pointer with 0x00FF.
// - Stack pointer addresses next free stack location.
// - Stack add sign-extends 8-bit immediate.
// - Stack low reset changes low byte only.
// - Program counter increments, or loads on change-of-flow.
// - After reset, program counter loads vector FFFE/FFFF.
// - Extended addressing reaches whole 64 Kbyte space.
// - Registers are internal, never on the bus.
// - Taken branch adds sign-extended 8-bit displacement.
// - Flag bits 6 and 5 always read one.
`timescale 1ns/1ps
`default_nettype none
module cpu_register_file
   import cpu_regs_pkg::*;
(
   // Clock and reset.
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   // Register operations from the sequencer.
   input  wire logic        op_valid_in,
   input  wire reg_op_t     op_in,
   input  wire logic [15:0] op_data_in,
   // Operand address request.
   input  wire logic        addr_req_in,
   input  wire addr_mode_t  addr_mode_in,
   input  wire logic [15:0] addr_operand_in,
   // Vector fetch memory port.
   input  wire logic        mem_ack_in,
   input  wire logic [7:0]  mem_rdata_in,
   output logic             mem_rd_out,
   output logic      [15:0] mem_addr_out,
   // Register contents and status.
   output logic             ready_out,
   output logic      [7:0]  acc_out,
   output logic      [7:0]  x_out,
   output logic      [7:0]  h_out,
   output logic      [15:0] sp_out,
   output logic      [15:0] pc_out,
   output logic      [7:0]  ccr_out,
   output logic      [15:0] ea_out
);

   typedef struct packed {
      vec_state_t  vstate;
      logic        ready;
      logic        rd;
      logic [15:0] raddr;
      logic [7:0]  vec_hi;
      logic [7:0]  acc;
      logic [7:0]  x;
      logic [7:0]  h;
      logic [15:0] sp;
      logic [15:0] pc;
      logic [7:0]  condition_flags_reg;
   } rf_state_t;

   rf_state_t st_q;
   rf_state_t st_d;
   logic      op_go;

   // Sign-extends a byte; shared by stack add and relative branch.
   function automatic logic [15:0] sext8(input logic [7:0] v);
      sext8 = {{8{v[7]}}, v};
   endfunction

   assign op_go = op_valid_in && (st_q.vstate == VS_RUN);

   // Vector fetch sequence, then register operations.
   always_comb
   begin
      st_d = st_q;
      case (st_q.vstate)
         VS_HIGH:
         begin
            st_d.rd    = 1'b1;
            st_d.raddr = VEC_ADDR_HIGH;
            if (st_q.rd && mem_ack_in)
            begin
               st_d.vec_hi = mem_rdata_in;
               st_d.raddr  = VEC_ADDR_LOW;
               st_d.vstate = VS_LOW;
            end
         end
         VS_LOW:
         begin
            if (mem_ack_in)
            begin
               st_d.pc     = {st_q.vec_hi, mem_rdata_in};
               st_d.rd     = 1'b0;
               st_d.ready  = 1'b1;
               st_d.vstate = VS_RUN;
            end
         end
         VS_RUN:
         begin
            if (op_go)
            begin
               case (op_in)
                  OP_LOAD_ACC:  st_d.acc = op_data_in[7:0];
                  OP_LOAD_X:    st_d.x = op_data_in[7:0];
                  OP_LOAD_H:    st_d.h = op_data_in[7:0];
                  OP_LOAD_HX:   {st_d.h, st_d.x} = op_data_in;
                  OP_LOAD_SP:   st_d.sp = op_data_in;
                  OP_ADD_SP:    st_d.sp = 16'(st_q.sp + sext8(op_data_in[7:0]));
                  OP_RESET_SPL: st_d.sp = {st_q.sp[15:8], SP_LOW_RESET};
                  OP_PUSH:      st_d.sp = 16'(st_q.sp - 16'h0001);
                  OP_PULL:      st_d.sp = 16'(st_q.sp + 16'h0001);
                  OP_PC_INC:    st_d.pc = 16'(st_q.pc + 16'h0001);
                  OP_PC_LOAD:   st_d.pc = op_data_in;
                  OP_PC_BRANCH: st_d.pc = 16'(st_q.pc + sext8(op_data_in[7:0]));
                  OP_LOAD_CCR:  st_d.condition_flags_reg = op_data_in[7:0] | CCR_ONES;
                  default:      st_d.condition_flags_reg = st_q.condition_flags_reg;
               endcase
            end
         end
         default:
         begin
            st_d.vstate = VS_HIGH;
            st_d.rd     = 1'b0;
            st_d.ready  = 1'b0;
         end
      endcase
   end

   // Reset touches only the fields that reset defines; accumulator and the
   // lower pointer byte keep their contents so software can inspect them.
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         st_q.vstate <= VS_HIGH;
         st_q.ready  <= 1'b0;
         st_q.rd     <= 1'b0;
         st_q.raddr  <= VEC_ADDR_HIGH;
         st_q.vec_hi <= 8'h00;
         st_q.h      <= H_RESET;
         st_q.sp     <= SP_RESET;
         st_q.pc     <= 16'h0000;
         st_q.condition_flags_reg    <= CCR_RESET;
         st_q.acc    <= st_q.acc;
         st_q.x      <= st_q.x;
      end
      else
         st_q <= st_d;
   end

   // Operand addresses; the register set itself has no bus address.
   cpu_addr_former u_addr_former (
      .clk_in     (clk_in),
      .rst_in     (rst_in),
      .req_in     (addr_req_in),
      .mode_in    (addr_mode_in),
      .operand_in (addr_operand_in),
      .pointer_in ({st_q.h, st_q.x}),
      .stack_in   (st_q.sp),
      .addr_out   (ea_out)
   );

   // Outputs come straight from the state register.
   assign mem_rd_out   = st_q.rd;
   assign mem_addr_out = st_q.raddr;
   assign ready_out    = st_q.ready;
   assign acc_out      = st_q.acc;
   assign x_out        = st_q.x;
   assign h_out        = st_q.h;
   assign sp_out       = st_q.sp;
   assign pc_out       = st_q.pc;
   assign ccr_out      = st_q.condition_flags_reg;

   default clocking cb @(posedge clk_in); endclocking

   // Power-up contents of the kept registers are unknown, so only a reset that
   // interrupts a running core can show whether they were kept.
   property p_acc_keep;
      (rst_in && ready_out) |=> acc_out == $past(acc_out);
   endproperty
   a_acc_keep: assert property (p_acc_keep) else $error("accumulator changed by reset");

   property p_ptr_reset;
      rst_in |=> h_out == H_RESET;
   endproperty
   a_ptr_reset: assert property (p_ptr_reset) else $error("pointer reset wrong");

   property p_x_keep;
      (rst_in && ready_out) |=> x_out == $past(x_out);
   endproperty
   a_x_keep: assert property (p_x_keep) else $error("lower pointer byte changed by reset");

   property p_sp_reset;
      rst_in |=> sp_out == SP_RESET;
   endproperty
   a_sp_reset: assert property (p_sp_reset) else $error("stack pointer reset wrong");

   property p_x_only;
      disable iff (rst_in) (op_go && op_in == OP_LOAD_X) |=> h_out == $past(h_out);
   endproperty
   a_x_only: assert property (p_x_only) else $error("upper pointer byte disturbed");

   property p_add_sp;
      disable iff (rst_in) (op_go && op_in == OP_ADD_SP)
         |=> sp_out == 16'($past(sp_out) + sext8($past(op_data_in[7:0])));
   endproperty
   a_add_sp: assert property (p_add_sp) else $error("stack add wrong");

   property p_spl;
      disable iff (rst_in) (op_go && op_in == OP_RESET_SPL)
         |=> sp_out == {$past(sp_out[15:8]), SP_LOW_RESET};
   endproperty
   a_spl: assert property (p_spl) else $error("stack low reset wrong");

   property p_pc_inc;
      disable iff (rst_in) (op_go && op_in == OP_PC_INC) |=> pc_out == 16'($past(pc_out) + 16'h0001);
   endproperty
   a_pc_inc: assert property (p_pc_inc) else $error("program counter not incremented");

   property p_branch;
      disable iff (rst_in) (op_go && op_in == OP_PC_BRANCH)
         |=> pc_out == 16'($past(pc_out) + sext8($past(op_data_in[7:0])));
   endproperty
   a_branch: assert property (p_branch) else $error("branch target wrong");

   property p_vector;
      disable iff (rst_in) (st_q.vstate == VS_LOW && mem_ack_in)
         |=> ready_out && !mem_rd_out && pc_out == {st_q.vec_hi, $past(mem_rdata_in)};
   endproperty
   a_vector: assert property (p_vector) else $error("vector load wrong");

   property p_vec_start;
      disable iff (rst_in) $fell(rst_in) |-> ##1 (mem_rd_out && mem_addr_out == VEC_ADDR_HIGH);
   endproperty
   a_vec_start: assert property (p_vec_start) else $error("vector fetch not started");

   property p_ccr_ones;
      disable iff (rst_in) ccr_out[6:5] == 2'b11;
   endproperty
   a_ccr_ones: assert property (p_ccr_ones) else $error("flag bits 6 and 5 not one");

   c_vector_done: cover property (disable iff (rst_in) $rose(ready_out));
   c_push:        cover property (disable iff (rst_in) op_go && op_in == OP_PUSH);
   c_branch_back: cover property (disable iff (rst_in)
                                   op_go && op_in == OP_PC_BRANCH && op_data_in[7]);

endmodule // cpu_register_file
`default_nettype wire

// ===== verif/cpu_register_file_tb.sv
/*
 * Self-checking bench for the CPU register file: vector fetch, operations
 * and operand addresses. Assumes the vector memory model beside it.
 */
`timescale 1ns/1ps
`default_nettype none
module cpu_register_file_tb;
   import cpu_regs_pkg::*;
   logic clk, rst, op_valid, areq, ack, rd, ready;
   reg_op_t op;
   addr_mode_t amode;
   logic [15:0] data, aop, vec, maddr, sp, pc, ea;
   logic [7:0]  rdata, acc, x, h, condition_flags_reg;
   logic [1:0]  wt;
   int errors = 0;
   int checks = 0;

   cpu_register_file u_dut (.clk_in(clk), .rst_in(rst), .op_valid_in(op_valid), .op_in(op),
      .op_data_in(data), .addr_req_in(areq), .addr_mode_in(amode), .addr_operand_in(aop),
      .mem_ack_in(ack), .mem_rdata_in(rdata), .mem_rd_out(rd), .mem_addr_out(maddr),
      .ready_out(ready), .acc_out(acc), .x_out(x), .h_out(h), .sp_out(sp), .pc_out(pc),
      .ccr_out(condition_flags_reg), .ea_out(ea));
   vector_mem_model u_mem (.clk_in(clk), .rst_in(rst), .vec_in(vec), .wait_in(wt),
      .mem_rd_in(rd), .mem_addr_in(maddr), .mem_ack_out(ack), .mem_rdata_out(rdata));

   // Free-running 20 MHz clock.
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic report_and_stop;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Inputs change 1 ns after the edge so the design samples settled values.
   task automatic op_do(input reg_op_t o, input logic [15:0] d);
      op_valid = 1'b1;
      op = o;
      data = d;
      @(posedge clk);
      #1;
   endtask

   // Reset, then fetch the vector; an operation offered meanwhile must be dropped.
   task automatic t_reset(input logic [15:0] v, input logic [1:0] w);
      int i;
      vec = v;
      wt = w;
      rst = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      rst = 1'b0;
      op_valid = 1'b1;
      op = OP_LOAD_ACC;
      data = 16'h00ee;
      for (i = 0; i < 40 && ready !== 1'b1; i++)
      begin
         @(posedge clk);
         #1;
      end
      op_valid = 1'b0;
      if (i >= 40)
      begin
         errors++;
         report_and_stop();
      end
      chk(pc, v);
      chk(h, 8'h00);
      chk(sp, 16'h00ff);
      chk(condition_flags_reg, 8'h68);
      chk(rd, 1'b0);
      $display("reset vector test done");
      // Let an edge pass so the next task does not raise op_valid in this step.
      @(posedge clk);
      #1;
   endtask

   // Back-to-back operations, judged the cycle after, but OP_LOAD_SP and OP_PC_LOAD through the next one and OP_LOAD_ACC after an OP_NOP.
   task automatic t_ops;
      op_do(OP_LOAD_HX, 16'h1234);
      chk({h, x}, 16'h1234);
      op_do(OP_LOAD_X, 16'h0056);
      chk({h, x}, 16'h1256);
      op_do(OP_LOAD_SP, 16'h1000);
      op_do(OP_ADD_SP, 16'h00fe);
      chk(sp, 16'h0ffe);
      op_do(OP_ADD_SP, 16'h0005);
      chk(sp, 16'h1003);
      op_do(OP_RESET_SPL, 16'h0000);
      chk(sp, 16'h10ff);
      op_do(OP_PUSH, 16'h0000);
      chk(sp, 16'h10fe);
      op_do(OP_PULL, 16'h0000);
      chk(sp, 16'h10ff);
      op_do(OP_PC_LOAD, 16'h8000);
      op_do(OP_PC_INC, 16'h0000);
      chk(pc, 16'h8001);
      op_do(OP_PC_BRANCH, 16'h0080);
      chk(pc, 16'h7f81);
      op_do(OP_PC_BRANCH, 16'h007f);
      chk(pc, 16'h8000);
      op_do(OP_LOAD_CCR, 16'h0000);
      chk(condition_flags_reg, 8'h60);
      op_do(OP_LOAD_CCR, 16'h009f);
      chk(condition_flags_reg, 8'hff);
      op_do(OP_LOAD_ACC, 16'h00a5);
      op_do(OP_NOP, 16'h00ff);
      chk(acc, 8'ha5);
      op_valid = 1'b0;
      $display("operation test done");
   endtask

   // Operand address for one mode, seen the cycle after the request.
   task automatic addr_do(input addr_mode_t m, input logic [15:0] o, input logic [15:0] e);
      areq = 1'b1;
      amode = m;
      aop = o;
      @(posedge clk);
      #1;
      chk(ea, e);
   endtask

   task automatic t_addr;
      addr_do(AM_DIRECT, 16'h1234, 16'h0034);
      addr_do(AM_EXTENDED, 16'hfffe, 16'hfffe);
      addr_do(AM_INDEXED, 16'h0010, 16'h1266);
      addr_do(AM_SP_INDEX, 16'h0001, 16'h1100);
      areq = 1'b0;
      $display("address test done");
   endtask

   // Main sequence; the second reset uses a slow memory and must keep A and X.
   initial
   begin
      {op_valid, areq} = 2'b00;
      op = OP_NOP;
      amode = AM_DIRECT;
      {data, aop, vec, wt} = 50'h0;
      t_reset(16'h1234, 2'h0);
      t_ops();
      t_addr();
      t_reset(16'h80f1, 2'h2);
      chk(acc, 8'ha5);
      chk(x, 8'h56);
      report_and_stop();
   end
endmodule // cpu_register_file_tb
`default_nettype wire

// ===== verif/vector_mem_model.sv
/*
 * Behavioural memory that answers the register file's reset-vector reads.
 * Assumes one clock shared with the register file and a vector set by the bench.
 */
`timescale 1ns/1ps
`default_nettype none
module vector_mem_model
(
   // Clock and reset.
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   // Behaviour set by the bench.
   input  wire logic [15:0] vec_in,
   input  wire logic [1:0]  wait_in,
   // Read port.
   input  wire logic        mem_rd_in,
   input  wire logic [15:0] mem_addr_in,
   output logic             mem_ack_out,
   output logic      [7:0]  mem_rdata_out
);
   logic [1:0] cnt_q;

   // Acks after wait_in idle cycles; data toggles when not valid so stale bytes show.
   always_ff @(posedge clk_in)
   begin
      mem_ack_out <= 1'b0;
      if (rst_in)
      begin
         cnt_q         <= 2'h0;
         mem_rdata_out <= 8'h5a;
      end
      else if (mem_rd_in && !mem_ack_out && cnt_q == wait_in)
      begin
         mem_ack_out   <= 1'b1;
         mem_rdata_out <= (mem_addr_in == 16'hfffe) ? vec_in[15:8] : vec_in[7:0];
         cnt_q         <= 2'h0;
      end
      else
      begin
         mem_rdata_out <= ~mem_rdata_out;
         cnt_q         <= (mem_rd_in && !mem_ack_out) ? cnt_q + 2'h1 : 2'h0;
      end
   end
endmodule // vector_mem_model
`default_nettype wire
